// [hdl/tdsr_status_regs.sv]
// thermal protection and device information status registers
`default_nettype none
module tdsr_status_regs
    import tdsr_pkg::*;
#(
    parameter longint SAFE_WAIT_CYC = TDSR_SAFE_WAIT_CYC
) (
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic         soft_reset,
    input  wire logic         restart_reset,
    input  wire tdsr_events_t ev,
    input  wire logic         crc_enabled,
    input  wire logic         devel_mode,
    input  wire tdsr_access_t acc,
    output logic [15:0]       rdata,
    output logic              rvalid,
    output logic              failsafe_req,
    output logic              module_disable,
    output logic              safe_wait_busy
);
    ////////////////////////////////////////////////////////////////////////
    logic [3:0]  therm_reg;
    logic        crcf_reg;
    logic [1:0]  prs_reg;
    logic [1:0]  wdf_reg;
    logic        spif_reg;
    logic        fail_reg;
    logic [4:0]  shut2_run_reg;
    logic        safe_mode_reg;
    logic        disable_reg;
    logic        failsafe_reg;
    logic [15:0] therm_view;
    logic [15:0] dev_view;
    logic        clr_therm;
    logic        clr_dev;
    logic        any_reset;

    function automatic logic hit(input tdsr_access_t a,
                                 input logic [6:0] addr);
        hit = (a.addr == addr);
    endfunction

    assign any_reset = soft_reset | restart_reset;
    assign clr_therm = acc.clr & hit(acc, TDSR_ADDR_THERM);
    assign clr_dev   = acc.clr & hit(acc, TDSR_ADDR_DEVINFO);

    ////////////////////////////////////////////////////////////////////////
    // thermal flags: sticky, set beats clear, restart keeps them
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            therm_reg <= 4'h0;
        end else if (soft_reset) begin
            therm_reg <= 4'h0;
        end else if (!restart_reset) begin
            if (clr_therm) begin
                therm_reg <= 4'h0;
            end
            if (ev.prewarn) begin
                therm_reg[TDSR_BIT_PREWARN] <= 1'b1;
            end
            if (ev.shut1) begin
                therm_reg[TDSR_BIT_SHUT1] <= 1'b1;
            end
            if (ev.shut2) begin
                therm_reg[TDSR_BIT_SHUT2] <= 1'b1;
            end
            if (ev.shut2 && shut2_run_reg >= TDSR_SAFE_LIMIT) begin
                therm_reg[TDSR_BIT_SAFE] <= 1'b1;
            end
        end
    end

    // consecutive second-level shutdown counter
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            shut2_run_reg <= 5'h00;
        end else if (soft_reset || ev.shut2_cool) begin
            shut2_run_reg <= 5'h00;
        end else if (ev.shut2 && shut2_run_reg != 5'h1f) begin
            shut2_run_reg <= shut2_run_reg + 5'h01;
        end
    end

    // once past the limit, later events use the long wait
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            safe_mode_reg <= 1'b0;
        end else if (soft_reset || ev.shut2_cool) begin
            safe_mode_reg <= 1'b0;
        end else if (ev.shut2 && shut2_run_reg >= TDSR_SAFE_LIMIT) begin
            safe_mode_reg <= 1'b1;
        end
    end

    tdsr_safe_timer #(
        .WAIT_CYC (SAFE_WAIT_CYC)
    ) u_safe_timer (
        .clock  (clock),
        .resetn (resetn),
        .start  (ev.shut2 & safe_mode_reg),
        .busy   (safe_wait_busy)
    );

    // module disable sticky until a thermal clear; fail-safe request pulses one cycle per shut2 event
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            disable_reg  <= 1'b0;
            failsafe_reg <= 1'b0;
        end else begin
            disable_reg  <= ev.shut1 | (disable_reg & ~clr_therm);
            failsafe_reg <= ev.shut2;
        end
    end
    assign module_disable = disable_reg;
    assign failsafe_req   = failsafe_reg;

    ////////////////////////////////////////////////////////////////////////
    // device information flags
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            crcf_reg <= 1'b0;
            spif_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else if (soft_reset) begin
            crcf_reg <= 1'b0;
            spif_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else if (!restart_reset) begin
            crcf_reg <= (ev.crc_fail & ~ev.crc_fixed_seq)
                        | (crcf_reg & ~clr_dev);
            spif_reg <= ev.spi_invalid | (spif_reg & ~clr_dev);
            fail_reg <= ev.failure | (fail_reg & ~clr_dev);
        end
    end

    // pre-restart state, only the host clears it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prs_reg <= TDSR_PRS_CLEARED;
        end else if (soft_reset) begin
            prs_reg <= TDSR_PRS_CLEARED;
        end else if (ev.sleep_entry) begin
            prs_reg <= TDSR_PRS_SLEEP;
        end else if (ev.restart_fail) begin
            prs_reg <= TDSR_PRS_RESTART;
        end else if (clr_dev && !restart_reset) begin
            prs_reg <= TDSR_PRS_CLEARED;
        end
    end

    // watchdog failure counter, device-cleared and saturating
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wdf_reg <= 2'h0;
        end else if (soft_reset) begin
            wdf_reg <= 2'h0;
        end else if (ev.wdog_fail) begin
            if (wdf_reg != TDSR_WDF_MAX) begin
                wdf_reg <= wdf_reg + 2'h1;
            end
        end else if (ev.wdog_clear) begin
            wdf_reg <= 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read views: reserved bits zero, live indicators
    always_comb begin
        therm_view = TDSR_RESET_VALUE;
        therm_view[3:0] = therm_reg;
        therm_view = therm_view & TDSR_THERM_RMASK;
        dev_view = TDSR_RESET_VALUE;
        dev_view[TDSR_BIT_CRCST] = crc_enabled;
        dev_view[TDSR_BIT_CRCF]  = crcf_reg;
        dev_view[TDSR_POS_PRS+:2] = prs_reg;
        dev_view[TDSR_BIT_DEVEL] = devel_mode;
        dev_view[TDSR_POS_WDF+:2] = wdf_reg;
        dev_view[TDSR_BIT_SPIF]  = spif_reg;
        dev_view[TDSR_BIT_FAIL]  = fail_reg;
        dev_view = dev_view & TDSR_DEV_RMASK;
    end

    // read data registered; the info register ignores crc_ok
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata  <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            rvalid <= 1'b0;
            rdata  <= 16'h0000;
            if (acc.rd && !any_reset) begin
                if (hit(acc, TDSR_ADDR_DEVINFO)) begin
                    rdata  <= dev_view;
                    rvalid <= 1'b1;
                end else if (hit(acc, TDSR_ADDR_THERM) && acc.crc_ok) begin
                    rdata  <= therm_view;
                    rvalid <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [hdl/tdsr_pkg.sv]
// package of constants and types for the thermal and device status registers
`default_nettype none
package tdsr_pkg;
    localparam logic [6:0]  TDSR_ADDR_THERM   = 7'h41;
    localparam logic [6:0]  TDSR_ADDR_DEVINFO = 7'h42;
    localparam logic [15:0] TDSR_RESET_VALUE  = 16'h0000;
    localparam logic [15:0] TDSR_THERM_KEEP   = 16'h000f;
    localparam logic [15:0] TDSR_DEV_KEEP     = 16'h03df;
    localparam logic [15:0] TDSR_THERM_RMASK  = 16'h000f;
    localparam logic [15:0] TDSR_DEV_RMASK    = 16'h03df;
    localparam int TDSR_BIT_SAFE   = 3;
    localparam int TDSR_BIT_SHUT2   = 2;
    localparam int TDSR_BIT_SHUT1   = 1;
    localparam int TDSR_BIT_PREWARN = 0;
    localparam int TDSR_BIT_CRCST  = 9;
    localparam int TDSR_BIT_CRCF   = 8;
    localparam int TDSR_POS_PRS    = 6;
    localparam int TDSR_BIT_DEVEL  = 4;
    localparam int TDSR_POS_WDF    = 2;
    localparam int TDSR_BIT_SPIF   = 1;
    localparam int TDSR_BIT_FAIL   = 0;
    localparam logic [4:0] TDSR_SAFE_LIMIT = 5'h10;
    localparam logic [1:0] TDSR_WDF_MAX    = 2'h3;
    localparam longint TDSR_SAFE_WAIT_S    = 64;
    localparam longint TDSR_CLK_HZ         = 100000000;
    localparam longint TDSR_SAFE_WAIT_CYC  = TDSR_SAFE_WAIT_S * TDSR_CLK_HZ;
    typedef enum logic [1:0] {
        TDSR_PRS_CLEARED = 2'h0,
        TDSR_PRS_RESTART = 2'h1,
        TDSR_PRS_SLEEP   = 2'h2
    } tdsr_prs_t;
    // hardware event strobes, one-cycle pulses
    typedef struct packed {
        logic prewarn;
        logic shut1;
        logic shut2;
        logic shut2_cool;
        logic crc_fail;
        logic crc_fixed_seq;
        logic restart_fail;
        logic sleep_entry;
        logic wdog_fail;
        logic wdog_clear;
        logic spi_invalid;
        logic failure;
    } tdsr_events_t;
    // register access from the serial frame decoder
    typedef struct packed {
        logic       rd;
        logic       clr;
        logic [6:0] addr;
        logic       crc_ok;
    } tdsr_access_t;
endpackage
`default_nettype wire

// [hdl/tdsr_safe_timer.sv]
// waiting-time counter started by each second-level shutdown once safe mode is set
`default_nettype none
module tdsr_safe_timer
    import tdsr_pkg::*;
#(
    parameter longint WAIT_CYC = TDSR_SAFE_WAIT_CYC
) (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic start,
    output logic      busy
);
    logic [39:0] count_reg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_reg <= 40'h00_0000_0000;
        end else if (start) begin
            count_reg <= 40'(WAIT_CYC);
        end else if (count_reg != 40'h00_0000_0000) begin
            count_reg <= count_reg - 40'h00_0000_0001;
        end
    end

    assign busy = (count_reg != 40'h00_0000_0000);
endmodule
`default_nettype wire

// [bench/tdsr_host_model.sv]
// serial host model issuing register read and clear accesses
`default_nettype none
module tdsr_host_model
    import tdsr_pkg::*;
(
    input  wire logic   clock,
    output tdsr_access_t acc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial acc = '0;
    // one access, held for exactly one sampling edge
    task automatic access(input logic r, input logic c, input logic [6:0] a,
                          input logic k);
        @(posedge clock);
        acc <= {r, c, a, k};
        @(posedge clock);
        acc <= '0;
    endtask
endmodule
`default_nettype wire

// [bench/tdsr_status_regs_sva.sv]
// assertions on the status register ports
`default_nettype none
module tdsr_status_regs_sva
    import tdsr_pkg::*;
#(
    parameter longint SAFE_WAIT_CYC = TDSR_SAFE_WAIT_CYC
) (
    input wire logic         clock,
    input wire logic         resetn,
    input wire logic         soft_reset,
    input wire logic         restart_reset,
    input wire tdsr_events_t ev,
    input wire logic         crc_enabled,
    input wire logic         devel_mode,
    input wire tdsr_access_t acc,
    input wire logic [15:0]  rdata,
    input wire logic         rvalid,
    input wire logic         failsafe_req,
    input wire logic         module_disable,
    input wire logic         safe_wait_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire logic quiet = !soft_reset && !restart_reset;
    wire logic th_clr = acc.clr && acc.addr == TDSR_ADDR_THERM;
    sequence dev_read;
        acc.rd && acc.addr == TDSR_ADDR_DEVINFO && quiet;
    endsequence
    sequence soft_then_read;
        (soft_reset && ev == '0) ##1 (quiet && ev == '0) ##1 dev_read;
    endsequence
    a_dev_read_ans:
        assert property (dev_read |=> rvalid) else $error("read lost");
    a_therm_refused:
        assert property (acc.rd && acc.addr == TDSR_ADDR_THERM && !acc.crc_ok
            |=> !rvalid) else $error("bad crc read answered");
    a_rsvd_therm_zero:
        assert property (rvalid && $past(acc.addr) == TDSR_ADDR_THERM
            |-> rdata[15:4] == 12'h000) else $error("thermal reserved set");
    a_rsvd_dev_zero:
        assert property (rvalid && $past(acc.addr) == TDSR_ADDR_DEVINFO
            |-> rdata[15:10] == 6'h00 && !rdata[5]) else $error("dev rsvd");
    a_live_bits:
        assert property (rvalid && $past(acc.addr) == TDSR_ADDR_DEVINFO
            |-> rdata[9] == $past(crc_enabled)
                && rdata[4] == $past(devel_mode))
        else $error("live bits wrong");
    a_failsafe_req:
        assert property (ev.shut2 && quiet |=> failsafe_req)
        else $error("fail-safe request missing");
    a_module_off:
        assert property (ev.shut1 && quiet |=> module_disable)
        else $error("module not disabled");
    a_flag_sticky:
        assert property (module_disable && !th_clr && quiet |=> module_disable)
        else $error("disable dropped");
    a_therm_clear:
        assert property (th_clr && quiet && !ev.shut1 |=> !module_disable)
        else $error("clear ignored");
    a_wait_hold:
        assert property ($rose(safe_wait_busy) |=> safe_wait_busy[*8])
        else $error("wait too short");
    a_soft_clear:
        assert property (soft_then_read |=> rvalid && (rdata & 16'h01cf) == 0)
        else $error("soft reset left bits");
endmodule
bind tdsr_status_regs tdsr_status_regs_sva #(.SAFE_WAIT_CYC(SAFE_WAIT_CYC))
    u_tdsr_status_regs_sva (.clock(clock), .resetn(resetn),
    .soft_reset(soft_reset), .restart_reset(restart_reset), .ev(ev),
    .crc_enabled(crc_enabled), .devel_mode(devel_mode), .acc(acc),
    .rdata(rdata), .rvalid(rvalid), .failsafe_req(failsafe_req),
    .module_disable(module_disable), .safe_wait_busy(safe_wait_busy));
`default_nettype wire

// [bench/tb_tdsr_status_regs.sv]
// self-checking bench for the status registers
`default_nettype none
module tb_tdsr_status_regs import tdsr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, resetn, soft_reset, restart_reset, crc_enabled, devel_mode;
    logic rvalid, safe_wait_busy;
    logic [15:0] rdata;
    tdsr_events_t ev;
    tdsr_access_t acc;
    int error_cnt = 0;
    int n_compared = 0;
    tdsr_status_regs #(
        .SAFE_WAIT_CYC (20)
    ) u_tdsr_status_regs (
        .clock          (clock),
        .resetn         (resetn),
        .soft_reset     (soft_reset),
        .restart_reset  (restart_reset),
        .ev             (ev),
        .crc_enabled    (crc_enabled),
        .devel_mode     (devel_mode),
        .acc            (acc),
        .rdata          (rdata),
        .rvalid         (rvalid),
        .failsafe_req   (),
        .module_disable (),
        .safe_wait_busy (safe_wait_busy)
    );
    tdsr_host_model u_tdsr_host_model (.clock(clock), .acc(acc));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // read, then look at the answer in the cycle it stands
    task automatic rd(input logic [6:0] a, input logic k, input logic [15:0] e,
                      input logic w);
        u_tdsr_host_model.access(1'b1, 1'b0, a, k);
        #1;
        check("rvalid", {15'h0, rvalid}, {15'h0, w});
        if (w) check("rdata", rdata, e);
    endtask
    task automatic pulse(input tdsr_events_t e);
        @(posedge clock);
        ev <= e;
        @(posedge clock);
        ev <= '0;
    endtask
    task automatic restart();
        @(posedge clock);
        restart_reset <= 1'b1;
        repeat (3) @(posedge clock);
        restart_reset <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {resetn, soft_reset, restart_reset, crc_enabled, devel_mode} = '0;
        ev = '0;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        rd(TDSR_ADDR_THERM, 1'b1, 16'h0000, 1'b1);
        rd(TDSR_ADDR_DEVINFO, 1'b0, 16'h0000, 1'b1);
        rd(TDSR_ADDR_THERM, 1'b0, 16'h0000, 1'b0);
        $display("test reset done");
        pulse(12'he00); // pre-warning, first and second level
        rd(TDSR_ADDR_THERM, 1'b1, 16'h0007, 1'b1);
        repeat (5) @(posedge clock);
        rd(TDSR_ADDR_THERM, 1'b1, 16'h0007, 1'b1);
        restart();
        rd(TDSR_ADDR_THERM, 1'b1, 16'h0007, 1'b1);
        u_tdsr_host_model.access(1'b0, 1'b1, TDSR_ADDR_THERM,
                                 1'b1);
        rd(TDSR_ADDR_THERM, 1'b1, 16'h0000, 1'b1);
        $display("test thermal done");
        pulse(12'h100); // cooling restarts the consecutive count
        repeat (16) pulse(12'h200);
        rd(TDSR_ADDR_THERM, 1'b1, 16'h0004, 1'b1);
        pulse(12'h200);
        rd(TDSR_ADDR_THERM, 1'b1, 16'h000c, 1'b1);
        pulse(12'h200);
        repeat (2) @(posedge clock);
        #1 check("busy", {15'h0, safe_wait_busy}, 16'h0001);
        repeat (30) @(posedge clock);
        #1 check("busy", {15'h0, safe_wait_busy}, 16'h0000);
        $display("test safe state done");
        @(posedge clock);
        crc_enabled <= 1'b1;
        devel_mode  <= 1'b1;
        pulse(12'h0a3); // crc fail, restart fail, invalid command, failure
        rd(TDSR_ADDR_DEVINFO, 1'b0, 16'h0353, 1'b1);
        repeat (4) pulse(12'h008);
        rd(TDSR_ADDR_DEVINFO, 1'b1, 16'h035f, 1'b1);
        restart();
        rd(TDSR_ADDR_DEVINFO, 1'b1, 16'h035f, 1'b1);
        u_tdsr_host_model.access(1'b0, 1'b1, TDSR_ADDR_DEVINFO,
                                 1'b1);
        rd(TDSR_ADDR_DEVINFO, 1'b1, 16'h021c, 1'b1);
        pulse(12'h0c0); // crc fail together with the fixed crc sequence
        rd(TDSR_ADDR_DEVINFO, 1'b1, 16'h021c, 1'b1);
        pulse(12'h090); // sleep entry and crc fail
        crc_enabled <= 1'b0;
        rd(TDSR_ADDR_DEVINFO, 1'b0, 16'h019c, 1'b1);
        pulse(12'h004); // watchdog counter cleared by device
        rd(TDSR_ADDR_DEVINFO, 1'b1, 16'h0190, 1'b1);
        @(posedge clock);
        soft_reset <= 1'b1;
        @(posedge clock);
        soft_reset <= 1'b0;
        rd(TDSR_ADDR_DEVINFO, 1'b1, 16'h0010, 1'b1);
        rd(TDSR_ADDR_THERM, 1'b1, 16'h0000, 1'b1);
        $display("test device done");
        report_and_stop();
    end
endmodule
`default_nettype wire
